// *** common/icsu_consts.vh ***
`ifndef ICSU_CONSTS_VH
`define ICSU_CONSTS_VH

// Command codes on cmd_code
`define ICSU_C_CLS 5'h00
`define ICSU_C_ESE 5'h01
`define ICSU_C_ESR 5'h02
`define ICSU_C_IDN 5'h03
`define ICSU_C_IST 5'h04
`define ICSU_C_OPC 5'h05
`define ICSU_C_OPT 5'h06
`define ICSU_C_PRE 5'h07
`define ICSU_C_PSC 5'h08
`define ICSU_C_RCL 5'h09
`define ICSU_C_RST 5'h0A
`define ICSU_C_SAV 5'h0B
`define ICSU_C_SRE 5'h0C
`define ICSU_C_STB 5'h0D
`define ICSU_C_TRG 5'h0E
`define ICSU_C_TST 5'h0F
`define ICSU_C_WAI 5'h10

// Status byte bit positions
`define ICSU_STB_MAV 4
`define ICSU_STB_ESB 5
`define ICSU_STB_MSS 6
// Summary inputs that the status byte takes from outside
`define ICSU_STB_EXT 8'h8F
// Writable bits of the service request enable mask
`define ICSU_SRE_WMASK 8'hBF
// Operation complete position in the event register
`define ICSU_ESR_OPC 0

`define ICSU_SLOT_W 2
`define ICSU_SLOTS 4
`define ICSU_CFG_W 16
`define ICSU_RSP_W 16
`define ICSU_IDN_LAST 3'h4
`define ICSU_OPT_N 4
`define ICSU_OPT_LAST 3'h3
`define ICSU_CFG_DEFAULT 16'h0000
`define ICSU_RSP_ONE 16'h0001

`endif

// *** rtl/icsu_common_status.v ***
// Function
// - Clear status zeroes status byte, event register and external event parts
// - Clear status leaves all enable masks and transition filters untouched
// - Clear status discards any pending response in the output buffer
// - Event enable mask loads 0..255; query returns it
// - Event register query returns value, then clears the register
// - Individual status query returns the parallel poll bit as 0 or 1
// - Operation complete sets event bit 0 once earlier commands finish
// - Operation complete query answers 1 only after earlier commands finish
// - Option query lists fixed positions, zero for missing options
// - Parallel poll enable mask loads 0..255; query returns it
// - Power-on clear flag decides whether enable masks survive power-up; readable
// - Save stores current settings into numbered slot
// - Recall loads and activates settings from numbered slot
// - Reset puts settings to defaults, same as system preset
// - Service request enable loads 0..255 with bit 6 forced to 0
// - Status byte query returns status byte unchanged
// - Trigger delivers a manual trigger to all waiting actions
// - Self-test query runs tests, returns 0 or positive error code
// - Wait holds later commands until earlier ones complete and settle
// - Identification query returns maker, type, part/serial, firmware list
`include "icsu_consts.vh"

module icsu_common_status #(
    // Identification words: arbitrary neutral values
    parameter [15:0] ID_MAKER = 16'h00A5,
    parameter [15:0] ID_TYPE = 16'h0101,
    parameter [15:0] ID_PART = 16'h0202,
    parameter [15:0] ID_SERIAL = 16'h0001,
    parameter [15:0] ID_FW = 16'h0100,
    parameter [3:0] OPT_INST = 4'h5
) (
    input wire clk,
    input wire rst,
    input wire cold_rst,
    input wire cmd_valid,
    input wire [4:0] cmd_code,
    input wire cmd_query,
    input wire [7:0] cmd_arg,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [15:0] rsp_data,
    output reg rsp_last,
    input wire rsp_ready,
    input wire exec_busy,
    input wire [7:0] evt_in,
    input wire [7:0] sum_in,
    output reg stat_clr,
    output reg trig,
    output reg preset,
    output reg tst_start,
    input wire tst_done,
    input wire [7:0] tst_code,
    input wire [15:0] cfg_in,
    output reg [15:0] cfg_out,
    output reg cfg_load,
    output reg [7:0] stb,
    output reg srq,
    output reg ist
);

    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_WAIT = 4'b0010;
    localparam [3:0] S_TEST = 4'b0100;
    localparam [3:0] S_LIST = 4'b1000;

    reg [3:0] state_r;
    reg [7:0] ese_r;
    reg [7:0] esr_r;
    reg [7:0] pre_r;
    reg [7:0] sre_r;
    reg psc_r;
    reg opc_pend_r;
    reg opc_query_r;
    reg list_idn_r;
    reg [2:0] idx_r;
    reg [15:0] slot_r [0:`ICSU_SLOTS-1];

    wire accept = cmd_valid & cmd_ready;
    wire [1:0] slot_idx = cmd_arg[`ICSU_SLOT_W-1:0];
    wire opc_done = opc_pend_r & ~exec_busy;
    wire [7:0] stb_nxt;
    wire [7:0] esr_clr;
    wire [15:0] list_data;
    wire [2:0] list_last;

    function [15:0] list_word;
        input idn;
        input [2:0] i;
        begin
            if (idn) begin
                case (i)
                    3'h0: list_word = ID_MAKER;
                    3'h1: list_word = ID_TYPE;
                    3'h2: list_word = ID_PART;
                    3'h3: list_word = ID_SERIAL;
                    default: list_word = ID_FW;
                endcase
            end else begin
                // Each option keeps its own position; absent ones read as zero
                list_word = OPT_INST[i[1:0]] ? {13'h0000, i} + 16'h0001 : 16'h0000;
            end
        end
    endfunction

    function [15:0] byte_rsp;
        input [7:0] v;
        begin
            byte_rsp = {8'h00, v};
        end
    endfunction

    assign list_data = list_word(list_idn_r, idx_r);
    assign list_last = list_idn_r ? `ICSU_IDN_LAST : `ICSU_OPT_LAST;

    // Summary bits from outside plus our own event summary, message-available and master summary
    assign stb_nxt = (sum_in & `ICSU_STB_EXT)
        | ({7'h00, |(esr_r & ese_r)} << `ICSU_STB_ESB)
        | ({7'h00, rsp_valid} << `ICSU_STB_MAV)
        | ({7'h00, |(stb & sre_r & `ICSU_SRE_WMASK)} << `ICSU_STB_MSS);

    // Event register clear on read or clear status
    assign esr_clr = (accept & cmd_query & (cmd_code == `ICSU_C_ESR))
        | (accept & (cmd_code == `ICSU_C_CLS)) ? 8'hFF : 8'h00;

    always @(posedge clk) begin
        if (cold_rst) begin
            psc_r <= 1'b1;
            ese_r <= 8'h00;
            sre_r <= 8'h00;
            pre_r <= 8'h00;
        end else if (rst) begin
            // Masks survive power-up only while the clear flag is 0
            if (psc_r) begin
                ese_r <= 8'h00;
                sre_r <= 8'h00;
                pre_r <= 8'h00;
            end
        end else if (accept & ~cmd_query) begin
            case (cmd_code)
                `ICSU_C_ESE: ese_r <= cmd_arg;
                `ICSU_C_PRE: pre_r <= cmd_arg;
                `ICSU_C_SRE: sre_r <= cmd_arg & `ICSU_SRE_WMASK;
                `ICSU_C_PSC: psc_r <= cmd_arg[0];
                default: psc_r <= psc_r;
            endcase
        end
    end

    always @(posedge clk) begin
        if (accept & ~cmd_query & (cmd_code == `ICSU_C_SAV))
            slot_r[slot_idx] <= cfg_in;
    end

    always @(posedge clk) begin
        if (rst | cold_rst) begin
            state_r <= S_IDLE;
            esr_r <= 8'h00;
            opc_pend_r <= 1'b0;
            opc_query_r <= 1'b0;
            list_idn_r <= 1'b0;
            idx_r <= 3'h0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            rsp_last <= 1'b0;
            stat_clr <= 1'b0;
            trig <= 1'b0;
            preset <= 1'b0;
            tst_start <= 1'b0;
            cfg_out <= `ICSU_CFG_DEFAULT;
            cfg_load <= 1'b0;
            stb <= 8'h00;
            srq <= 1'b0;
            ist <= 1'b0;
        end else begin
            stat_clr <= 1'b0;
            trig <= 1'b0;
            preset <= 1'b0;
            tst_start <= 1'b0;
            cfg_load <= 1'b0;
            stb <= stb_nxt;
            srq <= |(stb_nxt & sre_r & `ICSU_SRE_WMASK);
            ist <= |(stb_nxt & pre_r);
            // New events win over a clear in the same cycle
            esr_r <= (esr_r & ~esr_clr) | evt_in
                | ({7'h00, opc_done} << `ICSU_ESR_OPC);
            if (opc_done)
                opc_pend_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (rsp_valid & rsp_ready) begin
                        rsp_valid <= 1'b0;
                        rsp_last <= 1'b0;
                    end
                    if (accept) begin
                        // A setting command other than clear status, self-test, identification or option must not disturb a response still waiting
                        if (cmd_query) begin
                            rsp_valid <= 1'b1;
                            rsp_data <= 16'h0000;
                            rsp_last <= 1'b1;
                        end
                        case (cmd_code)
                            `ICSU_C_CLS: begin
                                rsp_valid <= 1'b0;
                                rsp_last <= 1'b0;
                                opc_pend_r <= 1'b0;
                                stat_clr <= 1'b1;
                            end
                            `ICSU_C_ESE: if (cmd_query) rsp_data <= byte_rsp(ese_r);
                            `ICSU_C_ESR: if (cmd_query) rsp_data <= byte_rsp(esr_r);
                            `ICSU_C_IST: if (cmd_query) rsp_data <= {15'h0000, ist};
                            `ICSU_C_PRE: if (cmd_query) rsp_data <= byte_rsp(pre_r);
                            `ICSU_C_PSC: if (cmd_query) rsp_data <= {15'h0000, psc_r};
                            `ICSU_C_SRE: if (cmd_query) rsp_data <= byte_rsp(sre_r);
                            `ICSU_C_STB: if (cmd_query) rsp_data <= byte_rsp(stb);
                            `ICSU_C_IDN, `ICSU_C_OPT: begin
                                rsp_valid <= 1'b0;
                                rsp_last <= 1'b0;
                                list_idn_r <= (cmd_code == `ICSU_C_IDN);
                                idx_r <= 3'h0;
                                cmd_ready <= 1'b0;
                                state_r <= S_LIST;
                            end
                            `ICSU_C_OPC: begin
                                if (cmd_query) begin
                                    rsp_valid <= 1'b0;
                                    opc_query_r <= 1'b1;
                                    cmd_ready <= 1'b0;
                                    state_r <= S_WAIT;
                                end else begin
                                    opc_pend_r <= 1'b1;
                                end
                            end
                            `ICSU_C_WAI: begin
                                opc_query_r <= 1'b0;
                                cmd_ready <= 1'b0;
                                state_r <= S_WAIT;
                            end
                            `ICSU_C_RCL: begin
                                cfg_out <= slot_r[slot_idx];
                                cfg_load <= 1'b1;
                            end
                            `ICSU_C_RST: begin
                                cfg_out <= `ICSU_CFG_DEFAULT;
                                cfg_load <= 1'b1;
                                preset <= 1'b1;
                            end
                            `ICSU_C_TRG: trig <= 1'b1;
                            `ICSU_C_TST: begin
                                rsp_valid <= 1'b0;
                                tst_start <= 1'b1;
                                cmd_ready <= 1'b0;
                                state_r <= S_TEST;
                            end
                            default: rsp_last <= rsp_last;
                        endcase
                    end
                end
                S_WAIT: begin
                    // Later commands stay blocked until the instrument is idle
                    if (~exec_busy) begin
                        if (opc_query_r) begin
                            rsp_valid <= 1'b1;
                            rsp_data <= `ICSU_RSP_ONE;
                            rsp_last <= 1'b1;
                        end
                        opc_query_r <= 1'b0;
                        cmd_ready <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_TEST: begin
                    if (tst_done) begin
                        rsp_valid <= 1'b1;
                        rsp_data <= byte_rsp(tst_code);
                        rsp_last <= 1'b1;
                        cmd_ready <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_LIST: begin
                    if (~rsp_valid) begin
                        rsp_valid <= 1'b1;
                        rsp_data <= list_data;
                        rsp_last <= (idx_r == list_last);
                    end else if (rsp_ready) begin
                        rsp_valid <= 1'b0;
                        if (rsp_last) begin
                            rsp_last <= 1'b0;
                            cmd_ready <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            idx_r <= idx_r + 3'h1;
                        end
                    end
                end
                default: begin
                    cmd_ready <= 1'b0;
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// *** verif/icsu_chk.sv ***
`include "icsu_consts.vh"

module icsu_chk (
    input wire clk,
    input wire rst,
    input wire cold_rst,
    input wire cmd_valid,
    input wire [4:0] cmd_code,
    input wire cmd_query,
    input wire cmd_ready,
    input wire rsp_valid,
    input wire [15:0] rsp_data,
    input wire rsp_last,
    input wire rsp_ready,
    input wire [7:0] evt_in,
    input wire stat_clr,
    input wire trig,
    input wire preset,
    input wire tst_start,
    input wire cfg_load,
    input wire [7:0] stb
);
    timeunit 1ns;
    timeprecision 1ns;
    wire acc = cmd_valid && cmd_ready;
    wire cls = acc && cmd_code == `ICSU_C_CLS;
    default clocking @(posedge clk); endclocking
    default disable iff (rst || cold_rst);
    a_trig_pulse: assert property (acc && cmd_code == `ICSU_C_TRG |=> trig)
        else $error("trigger pulse missing");
    a_preset_pulse: assert property (acc && cmd_code == `ICSU_C_RST |=> preset)
        else $error("preset pulse missing");
    a_clr_pulse: assert property (cls |=> stat_clr)
        else $error("status clear pulse missing");
    a_clr_flush: assert property (cls |=> !rsp_valid)
        else $error("response survived clear");
    // Allow the status byte its one-cycle lag behind the event register
    a_esb_cleared: assert property (cls && evt_in == 8'h00 ##1 evt_in == 8'h00 |=> !stb[5])
        else $error("event summary still set after clear");
    a_opc_answer: assert property (acc && cmd_code == `ICSU_C_OPC && cmd_query
        |-> ##[1:300] (rsp_valid && rsp_last && rsp_data == `ICSU_RSP_ONE))
        else $error("completion answer missing");
    a_test_start: assert property (acc && cmd_code == `ICSU_C_TST && cmd_query |=> tst_start)
        else $error("self test not started");
    a_recall_load: assert property (acc && cmd_code == `ICSU_C_RCL |=> cfg_load)
        else $error("recall did not load settings");
    a_rsp_hold: assert property (rsp_valid && !rsp_ready && !cmd_valid
        |=> rsp_valid && $stable(rsp_data))
        else $error("response dropped before taken");
endmodule

bind icsu_common_status icsu_chk u_chk (.clk(clk), .rst(rst), .cold_rst(cold_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_query(cmd_query), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .evt_in(evt_in), .stat_clr(stat_clr), .trig(trig), .preset(preset),
    .tst_start(tst_start), .cfg_load(cfg_load), .stb(stb));

// *** verif/icsu_ctrl_model.sv ***
module icsu_ctrl_model (
    input wire clk,
    input wire stall,
    input wire rsp_valid,
    input wire [15:0] rsp_data,
    output logic rsp_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] got [0:127];
    int n = 0;
    initial rsp_ready = 1'h0;
    // Ready only while a word is offered, so no word is taken twice
    always @(negedge clk)
        rsp_ready <= rsp_valid && !stall;
    always @(posedge clk)
        if (rsp_valid && rsp_ready) begin
            got[n[6:0]] <= rsp_data;
            n <= n + 1;
        end
endmodule

// *** verif/icsu_common_status_tb.sv ***
`include "icsu_consts.vh"

module icsu_common_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rst = 1'h1, cold_rst = 1'h1, cmd_valid = 1'h0, cmd_query = 1'h0;
    logic exec_busy = 1'h0, tst_done = 1'h0, stall = 1'h0;
    logic [4:0] cmd_code = 5'h00;
    logic [7:0] cmd_arg = 8'h00, evt_in = 8'h00, sum_in = 8'h00, tst_code = 8'h00;
    logic [15:0] cfg_in = 16'h0000;
    wire cmd_ready, rsp_valid, rsp_last, rsp_ready, stat_clr, trig, preset, tst_start;
    wire cfg_load, srq, ist;
    wire [15:0] rsp_data, cfg_out;
    wire [7:0] stb;
    int mismatches = 0, tests_run = 0;
    int n0;
    logic [15:0] idw [0:4] = '{16'h00A5, 16'h0101, 16'h0202, 16'h0001, 16'h0100};
    logic [15:0] opw [0:3] = '{16'h0001, 16'h0000, 16'h0003, 16'h0000};

    always #20 clk = ~clk;

    icsu_common_status dut (.clk(clk), .rst(rst), .cold_rst(cold_rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_query(cmd_query), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
        .exec_busy(exec_busy), .evt_in(evt_in), .sum_in(sum_in), .stat_clr(stat_clr),
        .trig(trig), .preset(preset), .tst_start(tst_start), .tst_done(tst_done),
        .tst_code(tst_code), .cfg_in(cfg_in), .cfg_out(cfg_out), .cfg_load(cfg_load),
        .stb(stb), .srq(srq), .ist(ist));
    icsu_ctrl_model pm (.clk(clk), .stall(stall), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_ready(rsp_ready));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Offer a command and hold it until the edge that sees ready high
    task automatic send(input logic [4:0] c, input logic q, input logic [7:0] a);
        int k;
        @(negedge clk);
        cmd_valid = 1'h1;
        cmd_code = c;
        cmd_query = q;
        cmd_arg = a;
        for (k = 0; cmd_ready !== 1'h1 && k < 500; k++)
            @(negedge clk);
        if (cmd_ready !== 1'h1)
            mismatches++;
        @(negedge clk);
        cmd_valid = 1'h0;
    endtask

    task automatic take(input int w);
        int k;
        for (k = 0; pm.n < n0 + w && k < 500; k++)
            @(negedge clk);
        if (pm.n < n0 + w)
            mismatches++;
    endtask

    task automatic q1(input logic [4:0] c, input logic [15:0] e);
        n0 = pm.n;
        send(c, 1'h1, 8'h00);
        take(1);
        chk(pm.got[n0], e);
    endtask

    task automatic t_masks;
        send(`ICSU_C_ESE, 1'h0, 8'hFF);
        q1(`ICSU_C_ESE, 16'h00FF);
        send(`ICSU_C_PRE, 1'h0, 8'hA5);
        q1(`ICSU_C_PRE, 16'h00A5);
        send(`ICSU_C_SRE, 1'h0, 8'hFF);
        q1(`ICSU_C_SRE, 16'h00BF);
        send(`ICSU_C_CLS, 1'h0, 8'h00);
        q1(`ICSU_C_ESE, 16'h00FF);
        q1(`ICSU_C_PRE, 16'h00A5);
    endtask

    task automatic t_events;
        @(negedge clk);
        evt_in = 8'h24;
        @(negedge clk);
        evt_in = 8'h00;
        repeat (3) @(negedge clk);
        chk(stb[5], 1'h1);
        chk(srq, 1'h1);
        chk(ist, 1'h1);
        q1(`ICSU_C_ESR, 16'h0024);
        q1(`ICSU_C_ESR, 16'h0000);
        sum_in = 8'h81;
        repeat (4) @(negedge clk);
        q1(`ICSU_C_STB, 16'h00C1);
        q1(`ICSU_C_STB, 16'h00C1);
        q1(`ICSU_C_IST, 16'h0001);
        sum_in = 8'h00;
        evt_in = 8'h01;
        @(negedge clk);
        evt_in = 8'h00;
        send(`ICSU_C_CLS, 1'h0, 8'h00);
        repeat (3) @(negedge clk);
        chk(stb, 8'h00);
        q1(`ICSU_C_ESR, 16'h0000);
        q1(`ICSU_C_IST, 16'h0000);
    endtask

    task automatic t_sync;
        exec_busy = 1'h1;
        n0 = pm.n;
        send(`ICSU_C_OPC, 1'h1, 8'h00);
        repeat (20) @(negedge clk);
        chk(16'(pm.n - n0), 16'h0000);
        exec_busy = 1'h0;
        take(1);
        chk(pm.got[n0], `ICSU_RSP_ONE);
        exec_busy = 1'h1;
        send(`ICSU_C_OPC, 1'h0, 8'h00);
        q1(`ICSU_C_ESR, 16'h0000);
        exec_busy = 1'h0;
        repeat (4) @(negedge clk);
        q1(`ICSU_C_ESR, 16'h0001);
        exec_busy = 1'h1;
        send(`ICSU_C_WAI, 1'h0, 8'h00);
        repeat (5) @(negedge clk);
        chk(cmd_ready, 1'h0);
        exec_busy = 1'h0;
        send(`ICSU_C_TRG, 1'h0, 8'h00);
    endtask

    task automatic t_lists(input logic [7:0] code);
        int i;
        stall = 1'h1;
        n0 = pm.n;
        send(`ICSU_C_IDN, 1'h1, 8'h00);
        repeat (6) @(negedge clk);
        stall = 1'h0;
        take(5);
        for (i = 0; i < 5; i++)
            chk(pm.got[n0 + i], idw[i]);
        n0 = pm.n;
        send(`ICSU_C_OPT, 1'h1, 8'h00);
        take(4);
        for (i = 0; i < 4; i++)
            chk(pm.got[n0 + i], opw[i]);
        n0 = pm.n;
        send(`ICSU_C_TST, 1'h1, 8'h00);
        repeat (3) @(negedge clk);
        tst_done = 1'h1;
        tst_code = code;
        @(negedge clk);
        tst_done = 1'h0;
        take(1);
        chk(pm.got[n0], {8'h00, code});
    endtask

    task automatic t_slots;
        cfg_in = 16'h1234;
        send(`ICSU_C_SAV, 1'h0, 8'h02);
        cfg_in = 16'h5678;
        send(`ICSU_C_SAV, 1'h0, 8'h01);
        cfg_in = 16'h0000;
        send(`ICSU_C_RCL, 1'h0, 8'h02);
        chk(cfg_out, 16'h1234);
        send(`ICSU_C_RCL, 1'h0, 8'h01);
        chk(cfg_out, 16'h5678);
        send(`ICSU_C_RST, 1'h0, 8'h00);
        chk(cfg_out, `ICSU_CFG_DEFAULT);
    endtask

    task automatic t_power(input logic [7:0] flag, input logic [15:0] e);
        send(`ICSU_C_PSC, 1'h0, flag);
        send(`ICSU_C_ESE, 1'h0, 8'h55);
        @(negedge clk);
        rst = 1'h1;
        @(negedge clk);
        rst = 1'h0;
        q1(`ICSU_C_ESE, e);
        q1(`ICSU_C_PSC, {8'h00, flag});
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rst = 1'h0;
        cold_rst = 1'h0;
        t_masks();
        t_events();
        t_sync();
        t_lists(8'h00);
        t_lists(8'h07);
        t_slots();
        t_power(8'h00, 16'h0055);
        t_power(8'h01, 16'h0000);
        wrap_up();
    end

    initial begin
        #3000000;
        mismatches++;
        wrap_up();
    end
endmodule
